// file: src/fpe_ctrl.v
// Keyed flash program/erase sequencer with its own flash byte array.
// Assumes core and debug requests are single-cycle strobes on sys_clk.
// Operation
// - Program one byte per operation, core or debug
// - Programming only clears bits to zero
// - Hardware times every program and erase
// - Stall core while program or erase runs
// - Keys 0xA5 then 0xF1 unlock one operation
// - Software flash reads are never locked
// - Key timing ignored, only order matters
// - Wrong or misordered key disables until reset
// - Flash write before full unlock also disables
// - Relock after every software program or erase; debug programs leave the key state alone
// - Write enable steers external moves to flash
// - Write enable held until software clears
// - Erase sets whole 512-byte page to 0xff
// - Erase enable plus write erases addressed page
// - Erase enable clear: write programs the byte
// - Stored data readable by code-space read
// - Blank part programmable only via debug port
`include "fpe_defs.vh"
module fpe_ctrl #(
    parameter WRITE_CYCLES = `FPE_WRITE_CYCLES,  // Program busy length
    parameter ERASE_CYCLES = `FPE_ERASE_CYCLES   // Erase busy length
) (
    input  wire        sys_clk,                 // System clock, 250 MHz
    input  wire        reset,                   // Asynchronous reset, high
    input  wire        store_write_enable,      // Control: route moves to flash
    input  wire        store_erase_enable,      // Control: erase instead of program
    input  wire        key_wr,                  // Strobe: write of unlock key register
    input  wire [7:0]  key_wdata,               // Key value
    input  wire        external_move_write,     // Strobe: core external-move write
    input  wire [12:0] xm_addr,                 // External-move address
    input  wire [7:0]  xm_wdata,                // External-move data
    input  wire        code_space_read,         // Strobe: core code-space read
    input  wire [12:0] cs_addr,                 // Code-space read address
    input  wire        dbg_wr,                  // Strobe: debug port byte program
    input  wire [12:0] dbg_addr,                // Debug program address
    input  wire [7:0]  dbg_wdata,               // Debug program data
    output reg  [7:0]  cs_rdata,                // Code-space read data
    output reg         cs_rvalid,               // Read data valid pulse
    output reg         dmem_wr,                 // Pass-through write to data memory
    output reg  [12:0] dmem_addr,               // Data memory address
    output reg  [7:0]  dmem_wdata,              // Data memory data
    output wire        core_stall,              // Core stalled while busy
    output wire        flash_busy,              // Operation in progress
    output wire [1:0]  key_state,               // 0 locked,1 half,2 open
    output wire        flash_disabled,          // Software writes blocked until reset
    output reg         op_done                  // Pulse at end of operation
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_PROG  = 3'b010;
    localparam ST_ERASE = 3'b100;
    localparam [1:0] KEY_LOCKED = 2'd0;
    localparam [1:0] KEY_HALF   = 2'd1;
    localparam [1:0] KEY_OPEN   = 2'd2;

    reg [7:0]  mem [0:`FPE_FLASH_BYTES-1];
    reg [2:0]  state_q;
    reg [1:0]  key_q;
    reg        dis_q;
    reg [31:0] cnt_q;
    reg [12:0] op_addr_q;
    reg [7:0]  op_data_q;
    reg [9:0]  erase_idx_q;
    reg        erase_run_q;

    assign core_stall     = (state_q != ST_IDLE);
    assign flash_busy     = core_stall;
    assign key_state      = key_q;
    assign flash_disabled = dis_q;

    wire sw_flash_wr = external_move_write && store_write_enable;
    wire sw_ok       = sw_flash_wr && key_q == KEY_OPEN && !dis_q;
    wire cnt_end     = (cnt_q == 32'd1);

    // Key checker: order only, timing free
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            key_q <= KEY_LOCKED;
            dis_q <= 1'b0;
        end else if (state_q == ST_IDLE) begin
            if (key_wr) begin
                if (key_q == KEY_LOCKED && key_wdata == `FPE_KEY_FIRST)
                    key_q <= KEY_HALF;
                else if (key_q == KEY_HALF && key_wdata == `FPE_KEY_SECOND)
                    key_q <= KEY_OPEN;
                else begin
                    key_q <= KEY_LOCKED;
                    dis_q <= 1'b1;
                end
            end else if (sw_flash_wr) begin
                key_q <= KEY_LOCKED;
                if (key_q != KEY_OPEN)
                    dis_q <= 1'b1;
            end
        end
    end

    // Operation sequencer and flash array
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            cnt_q       <= 32'd0;
            op_addr_q   <= 13'h0000;
            op_data_q   <= 8'hff;
            erase_idx_q <= 10'h000;
            erase_run_q <= 1'b0;
            op_done     <= 1'b0;
        end else begin
            op_done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (sw_ok && store_erase_enable) begin
                        state_q     <= ST_ERASE;
                        op_addr_q   <= xm_addr;
                        cnt_q       <= ERASE_CYCLES;
                        erase_idx_q <= 10'h000;
                        erase_run_q <= 1'b1;
                    end else if (sw_ok || dbg_wr) begin
                        state_q   <= ST_PROG;
                        op_addr_q <= sw_ok ? xm_addr : dbg_addr;
                        op_data_q <= sw_ok ? xm_wdata : dbg_wdata;
                        cnt_q     <= WRITE_CYCLES;
                    end
                end
                ST_PROG: begin
                    cnt_q <= cnt_q - 32'd1;
                    if (cnt_end) begin
                        state_q <= ST_IDLE;
                        op_done <= 1'b1;
                    end
                end
                ST_ERASE: begin
                    cnt_q <= cnt_q - 32'd1;
                    if (erase_run_q) begin
                        erase_idx_q <= erase_idx_q + 10'h001;
                        if (erase_idx_q[8:0] == 9'h1ff)
                            erase_run_q <= 1'b0;
                    end
                    if (cnt_end) begin
                        state_q <= ST_IDLE;
                        op_done <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Flash array write port, kept out of the reset processes
    always @(posedge sys_clk) begin
        if (state_q == ST_PROG && cnt_end)
            mem[op_addr_q] <= mem[op_addr_q] & op_data_q;
        else if (state_q == ST_ERASE && erase_run_q)
            mem[{op_addr_q[12:`FPE_PAGE_LSB], erase_idx_q[8:0]}] <= `FPE_ERASED_BYTE;
    end

    // Reads are never gated by the key; data memory pass-through
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cs_rdata   <= 8'h00;
            cs_rvalid  <= 1'b0;
            dmem_wr    <= 1'b0;
            dmem_addr  <= 13'h0000;
            dmem_wdata <= 8'h00;
        end else begin
            cs_rvalid <= code_space_read;
            if (code_space_read)
                cs_rdata <= mem[cs_addr];
            dmem_wr <= external_move_write && !store_write_enable;
            if (external_move_write && !store_write_enable) begin
                dmem_addr  <= xm_addr;
                dmem_wdata <= xm_wdata;
            end
        end
    end
endmodule // fpe_ctrl

// file: src/fpe_defs.vh
// Constants for the keyed flash program/erase sequencer.
// Assumes one 250 MHz system clock; included by fpe_ctrl.v only.
`ifndef FPE_DEFS_VH
`define FPE_DEFS_VH
`define FPE_KEY_FIRST     8'ha5
`define FPE_KEY_SECOND    8'hf1
`define FPE_ERASED_BYTE   8'hff
`define FPE_ADDR_W        13
`define FPE_PAGE_LSB      9
`define FPE_FLASH_BYTES   8192
`define FPE_CLK_MHZ       250
`define FPE_WRITE_TIME_US 40
`define FPE_ERASE_TIME_MS 10
`define FPE_WRITE_CYCLES  (`FPE_WRITE_TIME_US * `FPE_CLK_MHZ)
`define FPE_ERASE_CYCLES  (`FPE_ERASE_TIME_MS * 1000 * `FPE_CLK_MHZ)
`endif

// file: testbench/fpe_ctrl_sva.sv
// Port-level checker for fpe_ctrl.
// Assumes a bind from the bench top, one clock, async high reset.
module fpe_ctrl_sva #(parameter WC = 20, parameter EC = 600) (
    input wire logic sys_clk, reset, store_write_enable, key_wr, external_move_write,
    input wire logic code_space_read, cs_rvalid, dmem_wr, core_stall, flash_disabled, op_done,
    input wire logic [7:0] key_wdata, xm_wdata, dmem_wdata,
    input wire logic [12:0] xm_addr, dmem_addr,
    input wire logic [1:0] key_state);
    timeunit 1ns;
    timeprecision 1ps;
    int n_q;
    wire mv = external_move_write && !core_stall;
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) n_q <= 0;
        else n_q <= core_stall ? n_q + 1 : 0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_stall_on_write: assert property (mv && store_write_enable && key_state == 2'h2
        && !flash_disabled && !key_wr
        |=> core_stall && key_state == 2'h0) else $error("no stall or no relock");
    a_op_length: assert property ($fell(core_stall) |-> op_done
        && (n_q == WC || n_q == EC)) else $error("busy length wrong");
    a_pass_through: assert property (mv && !store_write_enable |=> dmem_wr
        && dmem_addr == $past(xm_addr) && dmem_wdata == $past(xm_wdata)) else $error("no pass");
    a_key_kept: assert property (mv && !store_write_enable && !key_wr
        |=> $stable(key_state)) else $error("key moved");
    a_early_write: assert property (mv && store_write_enable && key_state != 2'h2
        && !key_wr |=> flash_disabled && !core_stall) else $error("early write ran");
    a_wrong_first: assert property (key_wr && !core_stall && key_state == 2'h0
        && key_wdata != 8'ha5 |=> flash_disabled) else $error("bad key kept");
    a_stays_off: assert property (flash_disabled |=> flash_disabled) else $error("re-enabled");
    a_first_key: assert property (key_wr && !core_stall && key_state == 2'h0
        && key_wdata == 8'ha5 && !flash_disabled |=> key_state == 2'h1) else $error("no half");
    a_read_free: assert property (code_space_read && !core_stall |=> cs_rvalid) else $error("rd");
endmodule // fpe_ctrl_sva

// file: testbench/fpe_core_model.sv
// Core model: drives keys, moves, reads and debug writes.
// Assumes strobes last one cycle, changed at the falling edge.
module fpe_core_model (
    input wire logic sys_clk, core_stall,
    output logic store_write_enable, store_erase_enable, key_wr, external_move_write,
    output logic code_space_read, dbg_wr,
    output logic [7:0] key_wdata, xm_wdata, dbg_wdata,
    output logic [12:0] xm_addr, cs_addr, dbg_addr);
    timeunit 1ns;
    timeprecision 1ps;
    initial {store_write_enable, store_erase_enable, key_wr, external_move_write,
        code_space_read, dbg_wr, key_wdata, xm_wdata, dbg_wdata, xm_addr, cs_addr, dbg_addr} = 0;
    // Kind 0 key, 1 move, 2 read, 3 debug, 4 control bits from a[1:0]
    task automatic go(input int k, input logic [12:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        while (core_stall) @(negedge sys_clk);
        case (k)
            0: {key_wr, key_wdata} = {1'b1, d};
            1: {external_move_write, xm_addr, xm_wdata} = {1'b1, a, d};
            2: {code_space_read, cs_addr} = {1'b1, a};
            3: {dbg_wr, dbg_addr, dbg_wdata} = {1'b1, a, d};
            default: {store_write_enable, store_erase_enable} = a[1:0];
        endcase
        @(negedge sys_clk);
        {key_wr, external_move_write, code_space_read, dbg_wr} = 4'h0;
        {key_wdata, xm_wdata, dbg_wdata, xm_addr, cs_addr, dbg_addr} = ~{d, d, d, a, a, a};
    endtask
endmodule // fpe_core_model

// file: testbench/fpe_ctrl_tb.sv
// Self-checking bench for fpe_ctrl driven through the core model.
// Assumes the checker and core model files compile first.
module fpe_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 20, EC = 600;
    logic sys_clk, reset, store_write_enable, store_erase_enable, key_wr, external_move_write;
    logic code_space_read, dbg_wr, cs_rvalid, dmem_wr, core_stall, flash_busy, flash_disabled;
    logic op_done;
    logic [7:0] key_wdata, xm_wdata, dbg_wdata, cs_rdata, dmem_wdata;
    logic [12:0] xm_addr, cs_addr, dbg_addr, dmem_addr;
    logic [1:0] key_state;
    int n_fail = 0, num_checks = 0;
    fpe_ctrl #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) i_dut (.*);
    fpe_core_model i_core (.*);
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [12:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic rst;
        reset = 1;
        repeat (16) @(negedge sys_clk);
        reset = 0;
    endtask
    task automatic op(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
        i_core.go(4, {11'h0, c}, 0);
        i_core.go(0, 0, 8'ha5);
        i_core.go(0, 0, 8'hf1);
        i_core.go(1, a, d);
        chk(core_stall, 1);
        chk(flash_busy, 1);
        for (int i = 0; i < EC + 9 && op_done !== 1'b1; i++) @(negedge sys_clk);
        chk(op_done, 1);
        chk(key_state, 0);
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        i_core.go(2, a, 0);
        chk(cs_rvalid, 1);
        chk(cs_rdata, e);
    endtask
    initial begin
        rst();
        op(2'h3, 13'h0205, 8'h00);
        rd(13'h0200, 8'hff);
        rd(13'h03ff, 8'hff);
        op(2'h2, 13'h0210, 8'h5a);
        rd(13'h0210, 8'h5a);
        op(2'h2, 13'h0210, 8'h0f);
        rd(13'h0210, 8'h0a);
        $display("erase and program done");
        i_core.go(3, 13'h0220, 8'h33);
        repeat (WC + 4) @(negedge sys_clk);
        rd(13'h0220, 8'h33);
        i_core.go(4, 0, 0);
        i_core.go(0, 0, 8'ha5);
        i_core.go(1, 13'h0123, 8'h77);
        chk(dmem_addr, 13'h0123);
        chk(dmem_wdata, 8'h77);
        chk(dmem_wr, 1);
        chk(key_state, 1);
        i_core.go(0, 0, 8'hf1);
        chk(key_state, 2);
        i_core.go(4, 2, 0);
        i_core.go(1, 13'h0230, 8'h3c);
        chk(core_stall, 1);
        rd(13'h0230, 8'h3c);
        i_core.go(1, 13'h0210, 8'h00);
        chk(flash_disabled, 1);
        i_core.go(0, 0, 8'ha5);
        i_core.go(0, 0, 8'hf1);
        i_core.go(1, 13'h0210, 8'h00);
        chk(core_stall, 0);
        rd(13'h0210, 8'h0a);
        rst();
        i_core.go(0, 0, 8'h12);
        chk(flash_disabled, 1);
        $display("lock and key done");
        close_out();
    end
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule // fpe_ctrl_tb
bind fpe_ctrl fpe_ctrl_sva #(.WC(WRITE_CYCLES), .EC(ERASE_CYCLES)) i_sva (.*);
